//--- rtl/shunt_mon_pkg.sv
// Constants, register map and types for the shunt monitor sequencer
// How it works
// - All six signals: five conversions between revisits
// - Shunt only, three channels: two between
// - Full sequence is three times shunt plus bus
// - Shunt and bus times set apart, shared
// - Lone signal reconverts with no gap
// - Conversion length ignores other channel enables
// - Time settings span 140 us to 8.244 ms
// - Critical and warning open-drain pins pull low; PV and TC tied off
// - Each single shunt sample meets critical limit
// - Critical pin low when channel over limit
// - Critical limits reset to positive full scale
// - Limit writes act at once, anytime
// - Per-channel critical flags show the source
// - Sum selected single shunt samples into register
// - Summation off, or two or three channels
// - Sum over sum limit pulls critical low
// - Separate summation flag bit
// - Warning compares averaged shunt values
// - Average updated after every channel conversion
// - Averaging strength follows averaging field
// - Warning pin low on average over limit
// - Per-channel warning flags show the source
// - Mode 111: shunt then bus per channel
// - Disabled channels are skipped
// - Average adds scaled difference to stored value
// - Ready flag set when sequence completes
package shunt_mon_pkg;
   // Clock period and selectable conversion times
   localparam int unsigned CLK_NS = 5;
   localparam int unsigned T_US [8] = '{140, 204, 332, 588, 1100, 2116, 4156, 8244};
   // Least time rounds up to whole cycles
   function automatic int unsigned us_to_cyc(input int unsigned us);
      return (us * 1000 + CLK_NS - 1) / CLK_NS;
   endfunction
   localparam int unsigned CONV_CYC_DEF [8] = '{us_to_cyc(T_US[0]), us_to_cyc(T_US[1]),
      us_to_cyc(T_US[2]), us_to_cyc(T_US[3]), us_to_cyc(T_US[4]), us_to_cyc(T_US[5]),
      us_to_cyc(T_US[6]), us_to_cyc(T_US[7])};
   localparam int unsigned CNT_W = 21;
   // Register byte offsets; per-channel registers step by four
   localparam logic [7:0] OFS_CFG = 8'h00;
   localparam logic [7:0] OFS_SHUNT0 = 8'h04;
   localparam logic [7:0] OFS_BUS0 = 8'h10;
   localparam logic [7:0] OFS_CRIT0 = 8'h1C;
   localparam logic [7:0] OFS_WARN0 = 8'h28;
   localparam logic [7:0] OFS_SUM = 8'h34;
   localparam logic [7:0] OFS_SUMLIM = 8'h38;
   localparam logic [7:0] OFS_MASK = 8'h3C;
   // Configuration fields
   localparam int CFG_RST_B = 15;
   localparam int CFG_EN_LSB = 12;
   localparam int CFG_AVG_LSB = 9;
   localparam int CFG_BCT_LSB = 6;
   localparam int CFG_SCT_LSB = 3;
   localparam int CFG_MODE_LSB = 0;
   // Mask/enable fields
   localparam int MSK_SUMSEL_LSB = 12;
   localparam int MSK_CRIT_LSB = 7;
   localparam int MSK_SUMF_B = 6;
   localparam int MSK_WARN_LSB = 3;
   localparam int MSK_RDY_B = 0;
   // Reset values
   localparam logic [15:0] CFG_RESET = 16'h7127;
   localparam logic [15:0] LIM_RESET = 16'h7FFF;
   localparam logic [17:0] SUMLIM_RESET = 18'h1FFFF;
   // Bus responses
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Sequencer states
   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_CONV = 2'b10} seq_state_e;
endpackage

//--- rtl/shunt_monitor.sv
// Sequencer, averaging, limit alerts and AXI4-Lite registers of the shunt monitor
`timescale 1ns/100ps
`default_nettype none
module shunt_monitor #(
   parameter int unsigned CONV_CYC [8] = shunt_mon_pkg::CONV_CYC_DEF
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic adc_start,
   output logic [1:0] adc_chan,
   output logic adc_bus,
   input wire logic [15:0] adc_data,
   output logic crit_alert_o,
   output logic crit_alert_oe,
   output logic warn_alert_o,
   output logic warn_alert_oe,
   output logic pv_alert_o,
   output logic pv_alert_oe,
   output logic tc_alert_o,
   output logic tc_alert_oe
);
   ////////////////////////////////////////////////////////////////////////////
   // Elaboration check on conversion counts
   for (genvar k = 0; k < 8; k++)
   begin : g_chk
      if (CONV_CYC[k] < 2 || CONV_CYC[k] >= (1 << shunt_mon_pkg::CNT_W))
      begin : g_bad
         $error("Conversion count out of range");
      end
   end

   // Byte-lane merge for 16-bit registers
   function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
      return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction
   // Mapped address test, shared by read and write
   function automatic logic addr_hit(input logic [7:0] a);
      return a[1:0] == 2'b00 && a <= shunt_mon_pkg::OFS_MASK;
   endfunction
   // Next enabled slot after cur, with wrap mark
   function automatic logic [3:0] next_slot(input logic [2:0] cur, input logic [5:0] en);
      logic [3:0] r;
      logic [2:0] i;
      r = {1'b0, cur};
      for (int k = 6; k >= 1; k--)
      begin
         i = 3'((int'(cur) + k) % 6);
         if (en[i])
            r = {i <= cur, i};
      end
      return r;
   endfunction
   // Running average step
   function automatic logic [15:0] avg(input logic [15:0] old, input logic [15:0] nw, input logic [2:0] sh);
      logic signed [16:0] diff;
      diff = $signed({nw[15], nw}) - $signed({old[15], old});
      return 16'($signed({old[15], old}) + (diff >>> sh));
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State
   logic [15:0] cfg_q; // Configuration
   logic [15:0] crit_lim_q [3]; // Critical limits
   logic [15:0] warn_lim_q [3]; // Warning limits
   logic [15:0] raw_q [3]; // Last single shunt samples
   logic [15:0] shunt_q [3]; // Averaged shunt
   logic [15:0] bus_q [3]; // Averaged bus
   logic [17:0] sum_q, sum_lim_q; // Sum and its limit
   logic [2:0] sum_sel_q; // Summation channel select
   logic [2:0] crit_f_q, warn_f_q; // Channel flags
   logic sum_f_q, rdy_q, sw_rst_q, shot_q, single_q;
   shunt_mon_pkg::seq_state_e state_q;
   logic [2:0] slot_q; // Slot: channel*2 + bus
   logic [shunt_mon_pkg::CNT_W-1:0] cnt_q;
   // Bus channel state
   logic aw_got_q, w_got_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q;
   logic adc_start_q, adc_bus_q, crit_oe_q, warn_oe_q;
   logic [1:0] adc_chan_q;

   // Derived controls
   logic soft_rst, do_wr, cfg_wr, ar_hs, mask_rd, seq_go, conv_done, sum_on;
   logic [5:0] slots;
   logic [3:0] nxt;
   logic [2:0] first;
   assign soft_rst = !aresetn || sw_rst_q;
   assign do_wr = aw_got_q && w_got_q && !bvalid_q;
   assign cfg_wr = do_wr && awaddr_q == shunt_mon_pkg::OFS_CFG;
   assign ar_hs = arvalid && arready_q;
   assign mask_rd = ar_hs && araddr == shunt_mon_pkg::OFS_MASK;
   // Slot enables from channel enables and mode
   for (genvar c = 0; c < 3; c++)
   begin : g_slot
      assign slots[2*c] = cfg_q[shunt_mon_pkg::CFG_EN_LSB+c] && cfg_q[0];
      assign slots[2*c+1] = cfg_q[shunt_mon_pkg::CFG_EN_LSB+c] && cfg_q[1];
   end
   assign first = 3'(next_slot(3'd5, slots));
   assign nxt = next_slot(slot_q, slots);
   assign seq_go = state_q == shunt_mon_pkg::ST_IDLE && slots != 6'h00 && (cfg_q[2] || shot_q) && !cfg_wr;
   assign conv_done = state_q == shunt_mon_pkg::ST_CONV && cnt_q == 1 && !cfg_wr;
   assign sum_on = (sum_sel_q[0] + sum_sel_q[1] + sum_sel_q[2]) >= 2'd2;

   // Cycles of a slot from its shared time field
   function automatic logic [shunt_mon_pkg::CNT_W-1:0] cyc_of(input logic [2:0] s, input logic [15:0] cfg);
      return shunt_mon_pkg::CNT_W'(s[0] ? CONV_CYC[cfg[shunt_mon_pkg::CFG_BCT_LSB +: 3]]
                                        : CONV_CYC[cfg[shunt_mon_pkg::CFG_SCT_LSB +: 3]]);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Conversion sequencer
   always_ff @(posedge aclk)
   begin
      if (soft_rst)
      begin
         state_q <= shunt_mon_pkg::ST_IDLE;
         slot_q <= 3'h0;
         cnt_q <= '0;
         single_q <= 1'b0;
         adc_start_q <= 1'b0;
         adc_chan_q <= 2'h0;
         adc_bus_q <= 1'b0;
      end
      else
      begin
         adc_start_q <= 1'b0;
         case (state_q)
            shunt_mon_pkg::ST_IDLE:
            begin
               // Start a pass when running or a shot is pending
               if (seq_go)
               begin
                  state_q <= shunt_mon_pkg::ST_CONV;
                  slot_q <= first;
                  cnt_q <= cyc_of(first, cfg_q);
                  single_q <= !cfg_q[2];
                  adc_start_q <= 1'b1;
                  adc_chan_q <= first[2:1];
                  adc_bus_q <= first[0];
               end
            end
            shunt_mon_pkg::ST_CONV:
            begin
               if (cfg_wr)
                  state_q <= shunt_mon_pkg::ST_IDLE; // New setting restarts
               else if (conv_done)
               begin
                  if (nxt[3] && single_q)
                     state_q <= shunt_mon_pkg::ST_IDLE;
                  else
                  begin
                     // Next conversion starts without gap
                     slot_q <= nxt[2:0];
                     cnt_q <= cyc_of(nxt[2:0], cfg_q);
                     adc_start_q <= 1'b1;
                     adc_chan_q <= nxt[2:1];
                     adc_bus_q <= nxt[0];
                  end
               end
               else
                  cnt_q <= cnt_q - 1'b1;
            end
            default:
               state_q <= shunt_mon_pkg::ST_IDLE;
         endcase
      end
   end

   // Pending single shot, armed by a config write
   always_ff @(posedge aclk)
   begin
      if (soft_rst)
         shot_q <= 1'b0;
      else if (cfg_wr)
         shot_q <= !wdata_q[2] && wdata_q[1:0] != 2'b00;
      else if (seq_go)
         shot_q <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Results, averaging and sum
   always_ff @(posedge aclk)
   begin
      if (soft_rst)
      begin
         raw_q <= '{default: 16'h0000};
         shunt_q <= '{default: 16'h0000};
         bus_q <= '{default: 16'h0000};
         sum_q <= 18'h00000;
      end
      else
      begin
         if (conv_done && !slot_q[0])
         begin
            raw_q[slot_q[2:1]] <= adc_data;
            shunt_q[slot_q[2:1]] <= avg(shunt_q[slot_q[2:1]], adc_data, cfg_q[11:9]);
         end
         if (conv_done && slot_q[0])
            bus_q[slot_q[2:1]] <= avg(bus_q[slot_q[2:1]], adc_data, cfg_q[11:9]);
         // Sum of selected single samples
         sum_q <= sum_on ? 18'($signed(sum_sel_q[0] ? raw_q[0] : 16'h0000)
                             + $signed(sum_sel_q[1] ? raw_q[1] : 16'h0000)
                             + $signed(sum_sel_q[2] ? raw_q[2] : 16'h0000)) : 18'h00000;
      end
   end

   // Limit comparison flags, strictly greater, signed
   for (genvar c = 0; c < 3; c++)
   begin : g_flag
      always_ff @(posedge aclk)
      begin
         if (soft_rst)
         begin
            crit_f_q[c] <= 1'b0;
            warn_f_q[c] <= 1'b0;
         end
         else
         begin
            crit_f_q[c] <= $signed(raw_q[c]) > $signed(crit_lim_q[c]);
            warn_f_q[c] <= $signed(shunt_q[c]) > $signed(warn_lim_q[c]);
         end
      end
   end

   // Summation flag and alert pins
   always_ff @(posedge aclk)
   begin
      if (soft_rst)
      begin
         sum_f_q <= 1'b0;
         crit_oe_q <= 1'b0;
         warn_oe_q <= 1'b0;
      end
      else
      begin
         sum_f_q <= sum_on && $signed(sum_q) > $signed(sum_lim_q);
         crit_oe_q <= |crit_f_q || sum_f_q;
         warn_oe_q <= |warn_f_q;
      end
   end

   // Conversion-ready flag; a set beats a clear
   always_ff @(posedge aclk)
   begin
      if (soft_rst)
         rdy_q <= 1'b0;
      else if (conv_done && nxt[3])
         rdy_q <= 1'b1;
      else if (mask_rd || (cfg_wr && wdata_q[1:0] != 2'b00))
         rdy_q <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Software registers
   always_ff @(posedge aclk)
   begin
      if (soft_rst)
      begin
         cfg_q <= shunt_mon_pkg::CFG_RESET;
         crit_lim_q <= '{default: shunt_mon_pkg::LIM_RESET};
         warn_lim_q <= '{default: shunt_mon_pkg::LIM_RESET};
         sum_lim_q <= shunt_mon_pkg::SUMLIM_RESET;
         sum_sel_q <= 3'h0;
         sw_rst_q <= 1'b0;
      end
      else if (do_wr)
      begin
         if (cfg_wr)
         begin
            cfg_q <= wmerge(cfg_q, wdata_q, wstrb_q) & 16'h7FFF;
            sw_rst_q <= wstrb_q[1] && wdata_q[shunt_mon_pkg::CFG_RST_B];
         end
         for (int c = 0; c < 3; c++)
         begin
            if (awaddr_q == shunt_mon_pkg::OFS_CRIT0 + 8'(4 * c))
               crit_lim_q[c] <= wmerge(crit_lim_q[c], wdata_q, wstrb_q);
            if (awaddr_q == shunt_mon_pkg::OFS_WARN0 + 8'(4 * c))
               warn_lim_q[c] <= wmerge(warn_lim_q[c], wdata_q, wstrb_q);
         end
         if (awaddr_q == shunt_mon_pkg::OFS_SUMLIM)
         begin
            if (wstrb_q[0]) sum_lim_q[7:0] <= wdata_q[7:0];
            if (wstrb_q[1]) sum_lim_q[15:8] <= wdata_q[15:8];
            if (wstrb_q[2]) sum_lim_q[17:16] <= wdata_q[17:16];
         end
         if (awaddr_q == shunt_mon_pkg::OFS_MASK && wstrb_q[1])
            sum_sel_q <= wdata_q[shunt_mon_pkg::MSK_SUMSEL_LSB +: 3];
      end
   end

   // Read value for an address
   logic [31:0] rd_val;
   always_comb
   begin
      rd_val = 32'h0000_0000;
      if (araddr == shunt_mon_pkg::OFS_CFG)
         rd_val[15:0] = cfg_q;
      for (int c = 0; c < 3; c++)
      begin
         if (araddr == shunt_mon_pkg::OFS_SHUNT0 + 8'(4 * c)) rd_val[15:0] = shunt_q[c];
         if (araddr == shunt_mon_pkg::OFS_BUS0 + 8'(4 * c)) rd_val[15:0] = bus_q[c];
         if (araddr == shunt_mon_pkg::OFS_CRIT0 + 8'(4 * c)) rd_val[15:0] = crit_lim_q[c];
         if (araddr == shunt_mon_pkg::OFS_WARN0 + 8'(4 * c)) rd_val[15:0] = warn_lim_q[c];
      end
      if (araddr == shunt_mon_pkg::OFS_SUM) rd_val[17:0] = sum_q;
      if (araddr == shunt_mon_pkg::OFS_SUMLIM) rd_val[17:0] = sum_lim_q;
      if (araddr == shunt_mon_pkg::OFS_MASK)
      begin
         rd_val[shunt_mon_pkg::MSK_SUMSEL_LSB +: 3] = sum_sel_q;
         rd_val[shunt_mon_pkg::MSK_CRIT_LSB +: 3] = crit_f_q;
         rd_val[shunt_mon_pkg::MSK_SUMF_B] = sum_f_q;
         rd_val[shunt_mon_pkg::MSK_WARN_LSB +: 3] = warn_f_q;
         rd_val[shunt_mon_pkg::MSK_RDY_B] = rdy_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channels
   logic aw_got_d, w_got_d, bvalid_d;
   assign aw_got_d = (aw_got_q || (awvalid && awready_q)) && !do_wr;
   assign w_got_d = (w_got_q || (wvalid && wready_q)) && !do_wr;
   assign bvalid_d = do_wr || (bvalid_q && !bready);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         {aw_got_q, w_got_q, bvalid_q, awready_q, wready_q} <= 5'h00;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bresp_q <= shunt_mon_pkg::RESP_OK;
      end
      else
      begin
         aw_got_q <= aw_got_d;
         w_got_q <= w_got_d;
         bvalid_q <= bvalid_d;
         awready_q <= !aw_got_d && !bvalid_d;
         wready_q <= !w_got_d && !bvalid_d;
         if (awvalid && awready_q) awaddr_q <= awaddr;
         if (wvalid && wready_q)
         begin
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
         if (do_wr)
            bresp_q <= addr_hit(awaddr_q) ? shunt_mon_pkg::RESP_OK : shunt_mon_pkg::RESP_SLVERR;
      end
   end

   // AXI4-Lite read channels
   logic rvalid_d;
   assign rvalid_d = ar_hs || (rvalid_q && !rready);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         {arready_q, rvalid_q} <= 2'h0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= shunt_mon_pkg::RESP_OK;
      end
      else
      begin
         rvalid_q <= rvalid_d;
         arready_q <= !rvalid_d;
         if (ar_hs)
         begin
            rdata_q <= rd_val;
            rresp_q <= addr_hit(araddr) ? shunt_mon_pkg::RESP_OK : shunt_mon_pkg::RESP_SLVERR;
         end
      end
   end

   // Port drive; open-drain pins only pull low
   assign {awready, wready, bvalid, bresp} = {awready_q, wready_q, bvalid_q, bresp_q};
   assign {arready, rvalid, rdata, rresp} = {arready_q, rvalid_q, rdata_q, rresp_q};
   assign {adc_start, adc_chan, adc_bus} = {adc_start_q, adc_chan_q, adc_bus_q};
   assign {crit_alert_o, crit_alert_oe, warn_alert_o, warn_alert_oe} = {1'b0, crit_oe_q, 1'b0, warn_oe_q};
   assign {pv_alert_o, pv_alert_oe, tc_alert_o, tc_alert_oe} = 4'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking @(posedge aclk); endclocking
   default disable iff (soft_rst);
   a_crit_pin: assert property (crit_f_q != 3'h0 |=> crit_alert_oe) else $error("Critical pin not low");
   a_warn_pin: assert property (warn_f_q == 3'h0 |=> !warn_alert_oe) else $error("Warning pin stuck");
   a_strict_gt: assert property (raw_q[0] == crit_lim_q[0] |=> !crit_f_q[0]) else $error("Equal flagged");
   a_skip_off: assert property (state_q == shunt_mon_pkg::ST_CONV |-> slots[slot_q]) else $error("Disabled slot");
   a_no_gap: assert property (conv_done && !single_q |=> adc_start_q) else $error("Gap between conversions");
   a_conv_len: assert property (adc_start_q |-> cnt_q == cyc_of(slot_q, cfg_q)) else $error("Bad length");
   a_ready_set: assert property (conv_done && nxt[3] |=> rdy_q) else $error("Ready flag not set");
   a_avg_step: assert property (conv_done && !slot_q[0] && cfg_q[11:9] == 3'h0 |=>
      shunt_q[$past(slot_q[2:1])] == $past(adc_data)) else $error("Average not updated");
   a_sum_flag: assert property (!sum_on |=> !sum_f_q) else $error("Sum flag while off");
   c_single_shot: cover property (conv_done && nxt[3] && single_q);
   c_sum_alert: cover property (sum_f_q && crit_alert_oe);
   c_warn: cover property (warn_alert_oe);
endmodule // shunt_monitor
`default_nettype wire

//--- verif/adc_model.sv
// Behavioural converter that answers the monitor's conversion slots
`timescale 1ns/100ps
`default_nettype none
module adc_model (
   input wire logic aclk,
   input wire logic adc_start,
   input wire logic [1:0] adc_chan,
   input wire logic adc_bus,
   output logic [15:0] adc_data
);
   // Result per channel and signal, set by the bench
   logic [15:0] val [3][2] = '{default: 16'h0000};
   // Log of slots {chan, bus} and their lengths in cycles
   logic [2:0] slot_q [$];
   int len_q [$];
   int starts = 0;
   int cyc = 0;
   ////////////////////////////////////////////////////////////
   // First cycle shows the inverse, so an early sample is caught
   assign adc_data = adc_start ? ~val[adc_chan][adc_bus] : val[adc_chan][adc_bus];
   ////////////////////////////////////////////////////////////
   // Log each slot start and the length of the slot before it
   always @(posedge aclk)
   begin
      cyc = cyc + 1;
      if (adc_start === 1'b1)
      begin
         if (starts > 0)
            len_q.push_back(cyc);
         slot_q.push_back({adc_chan, adc_bus});
         starts = starts + 1;
         cyc = 0;
      end
   end
endmodule // adc_model
`default_nettype wire

//--- verif/shunt_monitor_tb.sv
// Self-checking bench for the shunt monitor sequencer and alerts
`timescale 1ns/100ps
`default_nettype none
module shunt_monitor_tb;
   // Short conversion counts keep the run brief
   localparam int unsigned CC [8] = '{2, 3, 4, 5, 6, 7, 8, 9};
   localparam int TMO = 4000;
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata, d, hs;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid, adc_start, adc_bus;
   logic crit_o, crit_oe, warn_o, warn_oe, pv_o, pv_oe, tc_o, tc_oe;
   logic [1:0] bresp, rresp, adc_chan, r;
   logic [15:0] adc_data;
   int num_errors = 0, n_tests = 0;
   ////////////////////////////////////////////////////////////
   // Clock, design and converter model
   always #2.5 aclk = ~aclk;
   shunt_monitor #(.CONV_CYC(CC)) i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .adc_start(adc_start), .adc_chan(adc_chan),
      .adc_bus(adc_bus), .adc_data(adc_data), .crit_alert_o(crit_o), .crit_alert_oe(crit_oe),
      .warn_alert_o(warn_o), .warn_alert_oe(warn_oe), .pv_alert_o(pv_o), .pv_alert_oe(pv_oe),
      .tc_alert_o(tc_o), .tc_alert_oe(tc_oe));
   adc_model i_adc (.aclk(aclk), .adc_start(adc_start), .adc_chan(adc_chan), .adc_bus(adc_bus), .adc_data(adc_data));
   ////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic complete_run();
      $display("TB: %0d checks, %0d errors", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Value compare
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] %0t %s: got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic note(input string s);
      $display("TB: test %s done", s);
   endtask
   // One AXI4-Lite transfer; result in d and r
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
      int n;
      @(posedge aclk);
      awaddr <= a;
      araddr <= a;
      wdata <= v;
      awvalid <= w;
      wvalid <= w;
      bready <= w;
      arvalid <= !w;
      rready <= !w;
      n = 0;
      do
      begin
         @(negedge aclk);
         n++;
         hs = {awready, wready, arready, w ? bvalid : rvalid};
         d = rdata;
         r = w ? bresp : rresp;
         @(posedge aclk);
         awvalid <= awvalid && !hs[3];
         wvalid <= wvalid && !hs[2];
         arvalid <= arvalid && !hs[1];
      end
      while (hs[0] !== 1'b1 && n < TMO);
      bready <= 1'b0;
      rready <= 1'b0;
      if (n >= TMO)
      begin
         chk(0, 1, "bus timeout");
         complete_run();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      xfer(1'b1, a, v);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string what);
      xfer(1'b0, a, 32'h0);
      chk(d, exp, what);
   endtask
   // Wait for k more slot starts
   task automatic wait_slots(input int k);
      int n;
      int c0;
      c0 = i_adc.starts;
      for (n = 0; i_adc.starts < c0 + k && n < TMO; n++)
         @(posedge aclk);
      if (n >= TMO)
      begin
         chk(0, 1, "slot timeout");
         complete_run();
      end
   endtask
   // Config word: bus time 1, shunt time 3
   function automatic logic [31:0] cfg(input logic [2:0] en, input logic [2:0] avg, input logic [2:0] mode);
      return {17'h0, en, avg, 3'h1, 3'h3, mode};
   endfunction
   // Slot order and lengths for one channel and mode choice
   task automatic chk_seq(input logic [2:0] en, input logic [2:0] mode);
      logic [2:0] ex [$];
      int b, j, tot;
      for (int c = 0; c < 3; c++)
         for (int s = 0; s < 2; s++)
            if (en[c] && mode[s])
               ex.push_back({c[1:0], s[0]});
      wr(shunt_mon_pkg::OFS_CFG, cfg(en, 3'h0, mode));
      b = i_adc.len_q.size() + 2;
      wait_slots(2 * ex.size() + 4);
      j = 0;
      tot = 0;
      foreach (ex[k])
         if (ex[k] === i_adc.slot_q[b])
            j = k;
      for (int k = 0; k < 2 * ex.size(); k++)
      begin
         chk(i_adc.slot_q[b + k], ex[(j + k) % ex.size()], "slot order");
         chk(i_adc.len_q[b + k], ex[(j + k) % ex.size()][0] ? CC[1] : CC[3], "slot length");
         tot += (k < ex.size()) ? i_adc.len_q[b + k] : 0;
      end
      if (ex.size() == 6)
         chk(tot, 3 * (CC[3] + CC[1]), "pass time");
   endtask
   ////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      int j;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rc(shunt_mon_pkg::OFS_CFG, {16'h0, shunt_mon_pkg::CFG_RESET}, "cfg reset");
      for (int i = 0; i < 6; i++)
         rc(shunt_mon_pkg::OFS_CRIT0 + 8'(4 * i), 32'h7FFF, "limit reset");
      xfer(1'b0, 8'h40, 32'h0);
      chk(r, shunt_mon_pkg::RESP_SLVERR, "unmapped");
      chk({crit_oe, warn_oe, pv_oe, tc_oe, crit_o, warn_o, pv_o, tc_o}, 8'h00, "pins idle");
      chk(shunt_mon_pkg::CONV_CYC_DEF[0], 140 * 200, "shortest time");
      chk(shunt_mon_pkg::CONV_CYC_DEF[7], 8244 * 200, "longest time");
      note("reset");
      chk_seq(3'b111, 3'b111);
      chk_seq(3'b111, 3'b101);
      chk_seq(3'b010, 3'b111);
      chk_seq(3'b100, 3'b110);
      wr(shunt_mon_pkg::OFS_CFG, cfg(3'b111, 3'h0, 3'b111));
      note("sequencer");
      // Critical limit on single samples
      i_adc.val[1][0] = 16'h0100;
      wr(shunt_mon_pkg::OFS_CRIT0 + 8'h04, 32'h0100);
      wait_slots(14);
      chk(crit_oe, 1'b0, "crit at limit");
      i_adc.val[1][0] = 16'h0101;
      wait_slots(14);
      chk({crit_oe, crit_o}, 2'b10, "crit over limit");
      rc(shunt_mon_pkg::OFS_MASK, 32'h0101, "mask read");
      chk(d[9:6], 4'b0100, "crit flags");
      i_adc.val[1][0] = 16'h00FF;
      wait_slots(14);
      chk(crit_oe, 1'b0, "crit cleared");
      note("critical");
      // Average settles one below; warning follows it
      i_adc.val[2][0] = 16'h0200;
      wait_slots(14);
      rc(shunt_mon_pkg::OFS_SHUNT0 + 8'h08, 32'h0200, "avg off");
      wr(shunt_mon_pkg::OFS_CFG, cfg(3'b111, 3'h1, 3'b111));
      i_adc.val[2][0] = 16'h0400;
      wr(shunt_mon_pkg::OFS_WARN0 + 8'h08, 32'h03FF);
      wait_slots(72);
      rc(shunt_mon_pkg::OFS_SHUNT0 + 8'h08, 32'h03FF, "avg settled");
      chk(warn_oe, 1'b0, "warn on average");
      wr(shunt_mon_pkg::OFS_WARN0 + 8'h08, 32'h03FE);
      wait_slots(14);
      chk({warn_oe, warn_o}, 2'b10, "warn over limit");
      rc(shunt_mon_pkg::OFS_MASK, 32'h0021, "mask read");
      chk(d[5:3], 3'b100, "warn flags");
      note("warning");
      // Summation of two, then three channels, then off
      wr(shunt_mon_pkg::OFS_CRIT0 + 8'h04, 32'h7FFF);
      for (int i = 0; i < 3; i++)
         i_adc.val[i][0] = 16'h0180;
      wr(shunt_mon_pkg::OFS_SUMLIM, 32'h0300);
      wr(shunt_mon_pkg::OFS_MASK, 32'h3000);
      wait_slots(14);
      rc(shunt_mon_pkg::OFS_SUM, 32'h0300, "sum of two");
      chk(crit_oe, 1'b0, "sum at limit");
      i_adc.val[1][0] = 16'h0181;
      wait_slots(14);
      chk(crit_oe, 1'b1, "sum over limit");
      rc(shunt_mon_pkg::OFS_MASK, 32'h3041, "mask read");
      chk(d[9:6], 4'b0001, "sum flag");
      wr(shunt_mon_pkg::OFS_MASK, 32'h7000);
      wait_slots(14);
      rc(shunt_mon_pkg::OFS_SUM, 32'h0481, "sum of three");
      wr(shunt_mon_pkg::OFS_MASK, 32'h0000);
      wait_slots(14);
      chk(crit_oe, 1'b0, "sum off");
      note("summation");
      // Single pass sets the ready flag and then stops
      wr(shunt_mon_pkg::OFS_CFG, cfg(3'b111, 3'h1, 3'b011));
      d = 32'h0;
      for (j = 0; d[0] !== 1'b1 && j < 200; j++)
         xfer(1'b0, shunt_mon_pkg::OFS_MASK, 32'h0);
      chk(d[0], 1'b1, "ready after pass");
      j = i_adc.starts;
      repeat (100) @(posedge aclk);
      chk(i_adc.starts - j, 0, "one pass only");
      // Software reset restores the limits
      wr(shunt_mon_pkg::OFS_CRIT0 + 8'h08, 32'h0001);
      wr(shunt_mon_pkg::OFS_CFG, 32'h8000);
      rc(shunt_mon_pkg::OFS_CRIT0 + 8'h08, 32'h7FFF, "limit after reset");
      rc(shunt_mon_pkg::OFS_CFG, {16'h0, shunt_mon_pkg::CFG_RESET}, "cfg after reset");
      note("single pass and reset");
      complete_run();
   end
endmodule // shunt_monitor_tb
`default_nettype wire
